// >>> hw/lift_pkg.sv
package lift_pkg;

  // ---------------------------------------------------------------
  // Contact inputs and function codes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CONTACTS     = 5;
  localparam logic [7:0]  FUNC_HS_LIMIT_UP = 8'h57;
  localparam logic [7:0]  FUNC_HS_LIMIT_DN = 8'h58;
  localparam logic [7:0]  RST_FUNC_SEL     = 8'h00;

  // ---------------------------------------------------------------
  // Parameter register numbers
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_SLIP_GAIN   = 16'h020F;
  localparam logic [15:0] ADDR_SLIP_DELAY  = 16'h0210;
  localparam logic [15:0] ADDR_SLIP_LIMIT  = 16'h0211;
  localparam logic [15:0] ADDR_SLIP_REGEN  = 16'h0212;
  localparam logic [15:0] ADDR_VOLT_LIMIT  = 16'h0213;
  localparam logic [15:0] ADDR_FUNC_SEL    = 16'h0400;

  // ---------------------------------------------------------------
  // Reset values and upper bounds
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_SLIP_GAIN    = 16'h000A;
  localparam logic [15:0] RST_SLIP_DELAY   = 16'h07D0;
  localparam logic [15:0] RST_SLIP_LIMIT   = 16'h00C8;
  localparam logic [15:0] RST_SLIP_REGEN   = 16'h0001;
  localparam logic [15:0] RST_VOLT_LIMIT   = 16'h0001;
  localparam logic [15:0] MAX_SLIP_GAIN    = 16'h0019;
  localparam logic [15:0] MAX_SLIP_DELAY   = 16'h2710;
  localparam logic [15:0] MAX_SLIP_LIMIT   = 16'h00E6;
  localparam logic [15:0] MAX_SEL_BIT      = 16'h0001;

  // ---------------------------------------------------------------
  // Control modes
  // ---------------------------------------------------------------
  localparam logic [1:0]  CTRL_VF          = 2'h0;
  localparam logic [1:0]  CTRL_OLV         = 2'h1;
  localparam logic [1:0]  CTRL_CLV         = 2'h2;

  // ---------------------------------------------------------------
  // Fixed-point scaling
  // ---------------------------------------------------------------
  localparam int unsigned TORQUE_SHIFT     = 12;
  localparam logic [15:0] RECIP10          = 16'h0CCD;
  localparam int unsigned RECIP10_SHIFT    = 15;
  localparam logic [15:0] RECIP100         = 16'h0290;
  localparam int unsigned RECIP100_SHIFT   = 16;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned DELAY_UNIT_NS    = 1000000;
  localparam int unsigned TICK_CYCLES      = DELAY_UNIT_NS / CLK_PERIOD_NS;

endpackage : lift_pkg

// >>> hw/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule : bit_sync

`default_nettype wire

// >>> hw/slip_delay_filter.sv
`timescale 1ns/1ps
`default_nettype none

module slip_delay_filter #(
  parameter int unsigned TICK_CYCLES = 200000
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic signed [31:0] x_i,
  input  wire logic        [15:0] tau_i,
  input  wire logic               clear_i,
  output logic signed      [31:0] y_o
);
  localparam int unsigned CW = $clog2(TICK_CYCLES);

  logic        [CW-1:0] cnt_q;
  logic        [CW-1:0] cnt_d;
  logic signed [31:0]   y_q;
  logic signed [31:0]   y_d;
  logic signed [39:0]   r_q;
  logic signed [39:0]   r_d;
  logic signed [39:0]   r_acc;
  logic signed [39:0]   tau_s;
  logic                 tick;

  // ---------------------------------------------------------------
  // First-order lag, one millisecond per tick
  // ---------------------------------------------------------------
  always_comb begin
    tick  = (cnt_q == CW'(TICK_CYCLES - 1));
    cnt_d = tick ? '0 : cnt_q + CW'(1);
    tau_s = $signed({24'h000000, tau_i});
    y_d   = y_q;
    r_d   = r_q;
    r_acc = r_q;
    if (clear_i) begin
      y_d = '0;
      r_d = '0;
    end else if (tau_i == 16'h0000) begin
      y_d = x_i;
      r_d = '0;
    end else begin
      if (tick) begin
        r_acc = r_q + 40'(x_i) - 40'(y_q);
      end
      if (r_acc >= tau_s) begin
        y_d   = y_q + 32'sd1;
        r_acc = r_acc - tau_s;
      end else if (r_acc <= -tau_s) begin
        y_d   = y_q - 32'sd1;
        r_acc = r_acc + tau_s;
      end
      r_d = r_acc;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      y_q   <= '0;
      r_q   <= '0;
    end else begin
      cnt_q <= cnt_d;
      y_q   <= y_d;
      r_q   <= r_d;
    end
  end

  assign y_o = y_q;

endmodule : slip_delay_filter

`default_nettype wire

// >>> hw/lift_speed_slip_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Any contact input may take function 87 (up limit) or 88 (down limit).
// - Up limit active with up command clamps speed to leveling speed.
// - Down limit active with down command clamps speed to leveling speed.
// - Add rated slip times gain, scaled by actual torque, to frequency.
// - Gain ranges 0.0 to 2.5, defaults 1.0, writable while running.
// - Zero gain disables slip compensation entirely.
// - Slip term passes a delay of 0 to 10000 ms, default 2000.
// - Slip term capped at 0 to 230 percent of rated slip, default 200.
// - One bit enables slip compensation in regeneration, default enabled.
// - Voltage limiter lowers output voltage above input voltage, default on.
// - Slip compensation only in V/f and open-loop vector modes.
module lift_speed_slip_ctrl #(
  parameter int unsigned NUM_IN      = lift_pkg::NUM_CONTACTS,
  parameter int unsigned TICK_CYCLES = lift_pkg::TICK_CYCLES
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic [NUM_IN-1:0]  contact_i,
  input  wire logic               fwd_cmd_i,
  input  wire logic               rev_cmd_i,
  input  wire logic               running_i,
  input  wire logic               regen_i,
  input  wire logic [1:0]         ctrl_mode_i,
  input  wire logic [15:0]        freq_ref_i,
  input  wire logic [15:0]        leveling_speed_i,
  input  wire logic [15:0]        motor_rated_slip_i,
  input  wire logic signed [15:0] torque_i,
  input  wire logic [15:0]        volt_ref_i,
  input  wire logic [15:0]        input_volt_i,
  input  wire logic               par_wr_i,
  input  wire logic               par_rd_i,
  input  wire logic [15:0]        par_addr_i,
  input  wire logic [15:0]        par_wdata_i,
  output logic      [15:0]        par_rdata_o,
  output logic                    par_ack_o,
  output logic                    par_err_o,
  output logic      [15:0]        freq_out_o,
  output logic      [15:0]        volt_out_o,
  output logic signed [15:0]      slip_term_o,
  output logic                    speed_limited_o,
  output logic                    volt_limited_o
);
  import lift_pkg::*;

  if (NUM_IN < 1 || NUM_IN > 8) begin : g_bad_num
    $error("NUM_IN must be 1 to 8");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  function automatic logic is_func_sel(input logic [15:0] a);
    return (a[15:3] == ADDR_FUNC_SEL[15:3]) &&
           ({1'b0, a[2:0]} < 4'(NUM_IN));
  endfunction : is_func_sel

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_IN+1:0] pins_s;
  logic [NUM_IN-1:0] contact_s;
  logic              fwd_s;
  logic              rev_s;

  bit_sync #(.W(NUM_IN + 2)) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({rev_cmd_i, fwd_cmd_i, contact_i}),
    .q_o     (pins_s)
  );
  assign contact_s = pins_s[NUM_IN-1:0];
  assign fwd_s     = pins_s[NUM_IN];
  assign rev_s     = pins_s[NUM_IN+1];

  // ---------------------------------------------------------------
  // Parameter registers
  // ---------------------------------------------------------------
  logic [15:0] gain_q,  gain_d;
  logic [15:0] delay_q, delay_d;
  logic [15:0] limit_q, limit_d;
  logic [15:0] regen_q, regen_d;
  logic [15:0] vlim_q,  vlim_d;
  logic [7:0]  fsel_q [NUM_IN];
  logic [7:0]  fsel_d [NUM_IN];
  logic [15:0] rdata_q, rdata_d;
  logic        ack_q,   ack_d;
  logic        err_q,   err_d;
  logic [2:0]  fidx;

  always_comb begin
    gain_d  = gain_q;
    delay_d = delay_q;
    limit_d = limit_q;
    regen_d = regen_q;
    vlim_d  = vlim_q;
    fsel_d  = fsel_q;
    rdata_d = 16'h0000;
    ack_d   = 1'b0;
    err_d   = 1'b0;
    fidx    = par_addr_i[2:0];
    if (par_wr_i) begin
      ack_d = 1'b1;
      case (par_addr_i)
        ADDR_SLIP_GAIN: begin
          if (par_wdata_i <= MAX_SLIP_GAIN) gain_d = par_wdata_i;
          else err_d = 1'b1;
        end
        ADDR_SLIP_DELAY: begin
          if (!running_i && par_wdata_i <= MAX_SLIP_DELAY) begin
            delay_d = par_wdata_i;
          end else err_d = 1'b1;
        end
        ADDR_SLIP_LIMIT: begin
          if (!running_i && par_wdata_i <= MAX_SLIP_LIMIT) begin
            limit_d = par_wdata_i;
          end else err_d = 1'b1;
        end
        ADDR_SLIP_REGEN: begin
          if (!running_i && par_wdata_i <= MAX_SEL_BIT) begin
            regen_d = par_wdata_i;
          end else err_d = 1'b1;
        end
        ADDR_VOLT_LIMIT: begin
          if (!running_i && par_wdata_i <= MAX_SEL_BIT) begin
            vlim_d = par_wdata_i;
          end else err_d = 1'b1;
        end
        default: begin
          if (is_func_sel(par_addr_i) && !running_i) begin
            fsel_d[fidx] = par_wdata_i[7:0];
          end else err_d = 1'b1;
        end
      endcase
    end else if (par_rd_i) begin
      ack_d = 1'b1;
      case (par_addr_i)
        ADDR_SLIP_GAIN:  rdata_d = gain_q;
        ADDR_SLIP_DELAY: rdata_d = delay_q;
        ADDR_SLIP_LIMIT: rdata_d = limit_q;
        ADDR_SLIP_REGEN: rdata_d = regen_q;
        ADDR_VOLT_LIMIT: rdata_d = vlim_q;
        default: begin
          if (is_func_sel(par_addr_i)) rdata_d = {8'h00, fsel_q[fidx]};
          else err_d = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Speed limit switches
  // ---------------------------------------------------------------
  logic [NUM_IN-1:0] up_hit;
  logic [NUM_IN-1:0] dn_hit;
  logic              limit_up;
  logic              limit_dn;
  logic [15:0]       freq_eff;

  for (genvar i = 0; i < NUM_IN; i++) begin : g_func
    assign up_hit[i] = contact_s[i] && (fsel_q[i] == FUNC_HS_LIMIT_UP);
    assign dn_hit[i] = contact_s[i] && (fsel_q[i] == FUNC_HS_LIMIT_DN);
  end

  assign limit_up = (|up_hit) && fwd_s;
  assign limit_dn = (|dn_hit) && rev_s;
  assign freq_eff = ((limit_up || limit_dn) &&
                     freq_ref_i > leveling_speed_i) ?
                    leveling_speed_i : freq_ref_i;

  // ---------------------------------------------------------------
  // Slip compensation
  // ---------------------------------------------------------------
  logic               slip_on;
  logic               slip_allowed;
  logic        [15:0] tmag;
  logic        [31:0] prod_rg;
  logic        [47:0] prod_t;
  logic        [51:0] prod_s;
  logic        [36:0] raw_mag;
  logic        [30:0] slip_mag;
  logic signed [31:0] slip_target;
  logic signed [31:0] filt_y;
  logic        [47:0] lim_prod;
  logic signed [31:0] lim;
  logic signed [31:0] term_eff;
  logic signed [33:0] fsum;

  assign slip_on      = (gain_q != 16'h0000) &&
                        (ctrl_mode_i != CTRL_CLV);
  assign slip_allowed = slip_on && (!regen_i || regen_q[0]);
  assign tmag         = torque_i[15] ? 16'(-torque_i) : 16'(torque_i);
  assign prod_rg      = motor_rated_slip_i * gain_q;
  assign prod_t       = prod_rg * tmag;
  assign prod_s       = 52'(prod_t >> TORQUE_SHIFT) * RECIP10;
  assign raw_mag      = prod_s[51:15];
  assign slip_mag     = (|raw_mag[36:31]) ? 31'h7FFFFFFF : raw_mag[30:0];
  assign slip_target  = !slip_allowed ? 32'sd0 :
                        torque_i[15] ? -$signed({1'b0, slip_mag}) :
                        $signed({1'b0, slip_mag});

  slip_delay_filter #(.TICK_CYCLES(TICK_CYCLES)) u_filter (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .x_i     (slip_target),
    .tau_i   (delay_q),
    .clear_i (!slip_on),
    .y_o     (filt_y)
  );

  assign lim_prod = (motor_rated_slip_i * limit_q) * RECIP100;
  assign lim      = $signed({1'b0, lim_prod[46:16]});

  always_comb begin
    term_eff = filt_y;
    if (!slip_on) term_eff = 32'sd0;
    else if (filt_y > lim) term_eff = lim;
    else if (filt_y < -lim) term_eff = -lim;
    fsum = $signed({18'h00000, freq_eff}) + 34'(term_eff);
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  logic [15:0]        fout_q, fout_d;
  logic [15:0]        vout_q, vout_d;
  logic signed [15:0] term_q, term_d;
  logic               slim_q, slim_d;
  logic               vsat_q, vsat_d;

  always_comb begin
    if (fsum < 0) fout_d = 16'h0000;
    else if (fsum > 34'sh0FFFF) fout_d = 16'hFFFF;
    else fout_d = fsum[15:0];
    if (term_eff > 32'sh7FFF) term_d = 16'sh7FFF;
    else if (term_eff < -32'sh8000) term_d = -16'sh8000;
    else term_d = term_eff[15:0];
    slim_d = limit_up || limit_dn;
    vsat_d = vlim_q[0] && (volt_ref_i > input_volt_i);
    vout_d = vsat_d ? input_volt_i : volt_ref_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gain_q  <= RST_SLIP_GAIN;
      delay_q <= RST_SLIP_DELAY;
      limit_q <= RST_SLIP_LIMIT;
      regen_q <= RST_SLIP_REGEN;
      vlim_q  <= RST_VOLT_LIMIT;
      fsel_q  <= '{default: RST_FUNC_SEL};
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      fout_q  <= 16'h0000;
      vout_q  <= 16'h0000;
      term_q  <= 16'sh0000;
      slim_q  <= 1'b0;
      vsat_q  <= 1'b0;
    end else begin
      gain_q  <= gain_d;
      delay_q <= delay_d;
      limit_q <= limit_d;
      regen_q <= regen_d;
      vlim_q  <= vlim_d;
      fsel_q  <= fsel_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
      fout_q  <= fout_d;
      vout_q  <= vout_d;
      term_q  <= term_d;
      slim_q  <= slim_d;
      vsat_q  <= vsat_d;
    end
  end

  assign par_rdata_o     = rdata_q;
  assign par_ack_o       = ack_q;
  assign par_err_o       = err_q;
  assign freq_out_o      = fout_q;
  assign volt_out_o      = vout_q;
  assign slip_term_o     = term_q;
  assign speed_limited_o = slim_q;
  assign volt_limited_o  = vsat_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_gain_wr;
    par_wr_i && par_addr_i == ADDR_SLIP_GAIN && par_wdata_i <= MAX_SLIP_GAIN;
  endsequence
  sequence s_locked_wr;
    par_wr_i && running_i && par_addr_i == ADDR_SLIP_DELAY;
  endsequence

  AST_GAIN_WRITE: assert property (
    s_gain_wr |=> gain_q == $past(par_wdata_i) && par_ack_o && !par_err_o)
    else $error("gain write not taken");
  AST_DELAY_LOCK: assert property (
    s_locked_wr |=> $stable(delay_q) && par_err_o)
    else $error("delay changed while running");
  AST_RANGES: assert property (
    gain_q <= MAX_SLIP_GAIN && limit_q <= MAX_SLIP_LIMIT)
    else $error("parameter out of range");
  AST_UP_CLAMP: assert property (
    limit_up |-> freq_eff <= leveling_speed_i ##1 speed_limited_o)
    else $error("up limit not applied");
  AST_FREE_RUN: assert property (
    !limit_up && !limit_dn |-> freq_eff == freq_ref_i)
    else $error("speed limited without cause");
  AST_GAIN_ZERO: assert property (
    gain_q == 16'h0000 |=> slip_term_o == 16'sh0000)
    else $error("slip term with zero gain");
  AST_CLV_NOSLIP: assert property (
    ctrl_mode_i == CTRL_CLV |=> slip_term_o == 16'sh0000)
    else $error("slip term in closed-loop mode");
  AST_CLAMP: assert property (
    term_eff <= lim && term_eff >= -lim)
    else $error("slip term above limit");
  AST_REGEN_OFF: assert property (
    regen_i && !regen_q[0] |-> slip_target == 32'sd0)
    else $error("slip in regeneration while disabled");
  AST_TAU_ZERO: assert property (
    delay_q == 16'h0000 && slip_on ##1 slip_on |-> filt_y == $past(slip_target))
    else $error("zero delay not pass-through");
  AST_VLIM: assert property (
    vlim_q[0] && volt_ref_i > input_volt_i
      |=> volt_limited_o && volt_out_o == $past(input_volt_i))
    else $error("output voltage not limited");

endmodule : lift_speed_slip_ctrl

`default_nettype wire

// >>> tb/lift_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Lift controller at the contact and command pins
// ------------------------------------------------------------
module lift_ctrl_model (
  input  wire logic       mclk_i,
  input  wire logic [4:0] contact_req_i,
  input  wire logic       up_req_i,
  input  wire logic       dn_req_i,
  input  wire logic       run_req_i,
  input  wire logic       regen_req_i,
  output logic      [4:0] contact_o = 5'h00,
  output logic            fwd_cmd_o = 1'b0,
  output logic            rev_cmd_o = 1'b0,
  output logic            running_o = 1'b0,
  output logic            regen_o   = 1'b0
);
  // Pins change off the sampling edge; up and down never together
  always @(negedge mclk_i) begin
    contact_o <= contact_req_i;
    fwd_cmd_o <= up_req_i & ~dn_req_i;
    rev_cmd_o <= dn_req_i & ~up_req_i;
    running_o <= run_req_i;
    regen_o   <= regen_req_i;
  end
endmodule : lift_ctrl_model

`default_nettype wire

// >>> tb/test_lift_speed_slip_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module test_lift_speed_slip_ctrl;
  import lift_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic               mclk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic [4:0]         contact_req = 5'h00;
  logic               up_req = 1'b0;
  logic               dn_req = 1'b0;
  logic               run_req = 1'b0;
  logic               regen_req = 1'b0;
  logic [4:0]         contact;
  logic               fwd_cmd;
  logic               rev_cmd;
  logic               running;
  logic               regen;
  logic [1:0]         ctrl_mode = CTRL_VF;
  logic [15:0]        freq_ref = 16'h0BB8;
  logic [15:0]        leveling = 16'h01F4;
  logic [15:0]        rated_slip = 16'h0064;
  logic signed [15:0] torque = 16'sh0000;
  logic [15:0]        volt_ref = 16'h0190;
  logic [15:0]        input_volt = 16'h012C;
  logic               par_wr = 1'b0;
  logic               par_rd = 1'b0;
  logic [15:0]        par_addr = 16'h0000;
  logic [15:0]        par_wdata = 16'h0000;
  logic [15:0]        par_rdata_o;
  logic               par_ack_o;
  logic               par_err_o;
  logic [15:0]        freq_out_o;
  logic [15:0]        volt_out_o;
  logic signed [15:0] slip_term_o;
  logic               speed_limited_o;
  logic               volt_limited_o;
  int                 errors = 0;
  int                 check_count = 0;
  logic [4:0]         cs [4] = '{5'h01, 5'h01, 5'h10, 5'h10};
  logic               us [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [15:0]        fs [4] = '{16'h01F4, 16'h0BB8, 16'h01F4, 16'h0BB8};

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  lift_ctrl_model u_lift_ctrl_model (
    .mclk_i(mclk_i), .contact_req_i(contact_req), .up_req_i(up_req),
    .dn_req_i(dn_req), .run_req_i(run_req), .regen_req_i(regen_req),
    .contact_o(contact), .fwd_cmd_o(fwd_cmd), .rev_cmd_o(rev_cmd),
    .running_o(running), .regen_o(regen)
  );

  lift_speed_slip_ctrl #(.NUM_IN(NUM_CONTACTS), .TICK_CYCLES(20))
  u_lift_speed_slip_ctrl (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .contact_i(contact),
    .fwd_cmd_i(fwd_cmd), .rev_cmd_i(rev_cmd), .running_i(running),
    .regen_i(regen), .ctrl_mode_i(ctrl_mode), .freq_ref_i(freq_ref),
    .leveling_speed_i(leveling), .motor_rated_slip_i(rated_slip),
    .torque_i(torque), .volt_ref_i(volt_ref),
    .input_volt_i(input_volt), .par_wr_i(par_wr), .par_rd_i(par_rd),
    .par_addr_i(par_addr), .par_wdata_i(par_wdata),
    .par_rdata_o(par_rdata_o), .par_ack_o(par_ack_o),
    .par_err_o(par_err_o), .freq_out_o(freq_out_o),
    .volt_out_o(volt_out_o), .slip_term_o(slip_term_o),
    .speed_limited_o(speed_limited_o), .volt_limited_o(volt_limited_o)
  );

  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16

  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask : test_end

  // ------------------------------------------------------------
  // Parameter port access
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d, input logic [15:0] ed,
                      input logic ee);
    int n;
    @(negedge mclk_i);
    par_wr = w;
    par_rd = ~w;
    par_addr = a;
    par_wdata = d;
    @(negedge mclk_i);
    par_wr = 1'b0;
    par_rd = 1'b0;
    n = 0;
    while (par_ack_o !== 1'b1 && n < 4) begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 4) begin
      errors++;
      $display("mismatch par_ack expected 1 seen timeout");
      tally_and_finish();
    end else begin
      chk1("par_err", ee, par_err_o);
      chk16("par_rdata", ed, par_rdata_o);
    end
  endtask : xfer

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic ee);
    xfer(1'b1, a, d, 16'h0000, ee);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] ed,
                    input logic ee);
    xfer(1'b0, a, 16'h0000, ed, ee);
  endtask : rd

  task automatic out_chk(input logic [15:0] ef, input logic [15:0] es,
                         input logic el);
    repeat (10) @(negedge mclk_i);
    chk16("freq_out", ef, freq_out_o);
    chk16("slip_term", es, slip_term_o);
    chk1("speed_limited", el, speed_limited_o);
  endtask : out_chk

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    rd(ADDR_SLIP_GAIN, 16'h000A, 1'b0);
    rd(ADDR_SLIP_DELAY, 16'h07D0, 1'b0);
    rd(ADDR_SLIP_LIMIT, 16'h00C8, 1'b0);
    rd(ADDR_SLIP_REGEN, 16'h0001, 1'b0);
    rd(ADDR_VOLT_LIMIT, 16'h0001, 1'b0);
    rd(ADDR_FUNC_SEL, 16'h0000, 1'b0);
    rd(16'h0214, 16'h0000, 1'b1);
    wr(ADDR_SLIP_GAIN, 16'h001A, 1'b1);
    wr(ADDR_SLIP_GAIN, 16'h0019, 1'b0);
    rd(ADDR_SLIP_GAIN, 16'h0019, 1'b0);
    wr(ADDR_SLIP_DELAY, 16'h2711, 1'b1);
    wr(ADDR_SLIP_LIMIT, 16'h00E7, 1'b1);
    wr(ADDR_SLIP_REGEN, 16'h0002, 1'b1);
    wr(ADDR_VOLT_LIMIT, 16'h0002, 1'b1);
    test_end("ranges");
    run_req = 1'b1;
    wr(ADDR_SLIP_DELAY, 16'h0000, 1'b1);
    wr(ADDR_SLIP_LIMIT, 16'h0000, 1'b1);
    wr(ADDR_SLIP_REGEN, 16'h0000, 1'b1);
    wr(ADDR_VOLT_LIMIT, 16'h0000, 1'b1);
    wr(ADDR_SLIP_GAIN, 16'h0000, 1'b0);
    rd(ADDR_SLIP_GAIN, 16'h0000, 1'b0);
    rd(ADDR_SLIP_DELAY, 16'h07D0, 1'b0);
    run_req = 1'b0;
    test_end("running");
    wr(ADDR_FUNC_SEL, 16'h0057, 1'b0);
    wr(ADDR_FUNC_SEL + 16'h0004, 16'h0058, 1'b0);
    for (int i = 0; i < 4; i++) begin
      contact_req = cs[i];
      up_req = us[i];
      dn_req = ~us[i];
      out_chk(fs[i], 16'h0000, fs[i] == 16'h01F4);
    end
    test_end("speed_limit");
    contact_req = 5'h00;
    up_req = 1'b1;
    dn_req = 1'b0;
    torque = 16'sh1000;
    wr(ADDR_SLIP_DELAY, 16'h0000, 1'b0);
    wr(ADDR_SLIP_GAIN, 16'h000A, 1'b0);
    out_chk(16'h0C1C, 16'h0064, 1'b0);
    ctrl_mode = CTRL_OLV;
    out_chk(16'h0C1C, 16'h0064, 1'b0);
    ctrl_mode = CTRL_CLV;
    out_chk(16'h0BB8, 16'h0000, 1'b0);
    ctrl_mode = CTRL_VF;
    torque = 16'sh0800;
    out_chk(16'h0BEA, 16'h0032, 1'b0);
    torque = 16'sh1000;
    wr(ADDR_SLIP_LIMIT, 16'h0019, 1'b0);
    out_chk(16'h0BD1, 16'h0019, 1'b0);
    wr(ADDR_SLIP_LIMIT, 16'h00C8, 1'b0);
    torque = 16'shF000;
    regen_req = 1'b1;
    out_chk(16'h0B54, 16'hFF9C, 1'b0);
    wr(ADDR_SLIP_REGEN, 16'h0000, 1'b0);
    out_chk(16'h0BB8, 16'h0000, 1'b0);
    regen_req = 1'b0;
    test_end("slip");
    torque = 16'sh0000;
    out_chk(16'h0BB8, 16'h0000, 1'b0);
    wr(ADDR_SLIP_DELAY, 16'h0005, 1'b0);
    torque = 16'sh1000;
    repeat (5) @(negedge mclk_i);
    chk1("slip_lagging", 1'b1, slip_term_o < 16'sd100);
    repeat (3000) @(negedge mclk_i);
    chk1("slip_settled", 1'b1,
         slip_term_o > 16'sd89 && slip_term_o < 16'sd111);
    test_end("delay");
    chk16("volt_out", 16'h012C, volt_out_o);
    chk1("volt_limited", 1'b1, volt_limited_o);
    wr(ADDR_VOLT_LIMIT, 16'h0000, 1'b0);
    repeat (4) @(negedge mclk_i);
    chk16("volt_out", 16'h0190, volt_out_o);
    chk1("volt_limited", 1'b0, volt_limited_o);
    test_end("voltage");
    tally_and_finish();
  end
endmodule : test_lift_speed_slip_ctrl

`default_nettype wire
